/* File: bench/mcsync_ctrl_props.sv */
module mcsync_props (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire mcsync_pkg::mcsync_req_t i_reg,
  input wire mcsync_pkg::mcsync_rsp_t o_reg,
  input wire logic o_sync_locked,
  input wire logic o_sync_lost,
  input wire logic o_aligned_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Register port and status checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  AST_RD_ANS: assert property (i_reg.rd |=> o_reg.rvalid)
    else $error("read not answered");
  AST_RD_NONE: assert property (!i_reg.rd |=> !o_reg.rvalid)
    else $error("stray read answer");
  AST_OFF: assert property ((i_reg.wr && i_reg.addr == 8'h10 &&
    !i_reg.wdata[7]) |=> !o_sync_locked [*8])
    else $error("locked while disabled");
  AST_LOST: assert property ($rose(o_sync_lost) |-> !o_sync_locked)
    else $error("lost while still locked");
  AST_STROBE: assert property (o_aligned_strobe |=> !o_aligned_strobe)
    else $error("strobe wider than a cycle");
  AST_STAT: assert property ((i_reg.rd && i_reg.addr == 8'h12) |=>
    o_reg.rdata == {$past(o_sync_lost), $past(o_sync_locked), 6'h00})
    else $error("status read mismatch");
  AST_REQ: assert property ((i_reg.rd && i_reg.addr == 8'h11) |=>
    o_reg.rdata[7:6] == 2'h0)
    else $error("request upper bits set");
  AST_UNMAP: assert property ((i_reg.rd && i_reg.addr > 8'h13) |=>
    o_reg.rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RST: assert property (disable iff (1'b0) i_rst |=>
    (!o_sync_locked && !o_sync_lost && !o_aligned_strobe && !o_reg.rvalid))
    else $error("outputs not cleared by reset");
endmodule : mcsync_props

bind mcsync_ctrl mcsync_props u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_reg(i_reg), .o_reg(o_reg), .o_sync_locked(o_sync_locked),
  .o_sync_lost(o_sync_lost), .o_aligned_strobe(o_aligned_strobe));

/* File: bench/mcsync_sync_src.sv */
module mcsync_sync_src (
  input wire logic i_clk,
  input wire logic [5:0] i_phase,
  output logic o_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Shared sync source
  // A new phase is taken only at wrap, so a move makes no runt pulse while the old and new phases are 56 or less.
  logic [5:0] cnt = 6'h00;
  logic [5:0] ph = 6'h00;
  initial o_sync = 1'b0;
  always @(posedge i_clk) begin
    cnt <= #1 cnt + 6'h01;
    if (cnt == 6'h3F) ph <= #1 i_phase;
    o_sync <= #1 (6'(cnt - ph) < 6'h08);
  end
endmodule : mcsync_sync_src

/* File: bench/tb_mcsync_ctrl.sv */
module tb_mcsync_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } mcsync_row_t;
  localparam mcsync_row_t ROWS [9] = '{'{1'b0, 8'h10, 8'h00, 8'h48},
    '{1'b0, 8'h11, 8'h00, 8'h00}, '{1'b0, 8'h12, 8'h00, 8'h00},
    '{1'b0, 8'h13, 8'h00, 8'h00}, '{1'b1, 8'h11, 8'hFF, 8'h3F},
    '{1'b1, 8'h11, 8'h2A, 8'h2A}, '{1'b1, 8'h12, 8'hFF, 8'h00},
    '{1'b1, 8'h20, 8'hAA, 8'h00}, '{1'b1, 8'h10, 8'h0F, 8'h0F}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sync;
  logic locked;
  logic lost;
  logic stb;
  logic [5:0] ph = 6'h05;
  logic [7:0] v;
  logic [7:0] r0;
  mcsync_pkg::mcsync_req_t req = '0;
  mcsync_pkg::mcsync_rsp_t rsp;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0;
  int t1;
  int n_stb = 0;
  mcsync_sync_src u_src (.i_clk(clk), .i_phase(ph), .o_sync(sync));
  mcsync_ctrl u_dut (.i_sys_clk(clk), .i_rst(rst), .i_sync(sync),
    .i_reg(req), .o_reg(rsp), .o_sync_locked(locked), .o_sync_lost(lost),
    .o_aligned_strobe(stb));
  // ==========================================================================
  // Clock and helpers
  initial forever #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    #1 req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 req = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    #1 req.rd = 1'b0;
    d = rsp.rdata;
  endtask : rd
  task automatic lock(input logic [7:0] c, output logic [7:0] rb);
    wr(8'h10, c);
    repeat (600) if (locked !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    #1 chk("locked", 8'h01, {7'h00, locked});
    rd(8'h13, rb);
  endtask : lock
  // Keeps the last strobe seen; strobes repeat every 64 cycles.
  task automatic stb_at(output int t);
    repeat (130) begin
      @(posedge clk);
      #1 if (stb === 1'b1) t = cyc % 64;
    end
  endtask : stb_at
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Sequence
  initial begin
    #(8 * 20000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      chk("row", ROWS[i].e, v);
    end
    wr(8'h11, 8'h00);
    lock(8'hC8, r0);
    stb_at(t0);
    wr(8'h11, 8'h0A);
    stb_at(t1);
    chk("offset", 8'h0A, 8'((t1 - t0 + 64) % 64));
    ph = 6'h08;
    repeat (200) if (lost !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    rd(8'h12, v);
    chk("status", 8'h80, v);
    lock(8'hC8, v);
    chk("phase", r0 + 8'h0C, v);
    rd(8'h12, v);
    chk("status", 8'h40, v);
    lock(8'hCA, v);
    chk("average", r0 + 8'h0C, v);
    lock(8'hC0, v);
    chk("falling", r0 + 8'h2C, v);
    lock(8'h88, v);
    chk("fifo", 8'h00, v & 8'hC0);
    repeat (32) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      #1 if (stb === 1'b1) n_stb++;
    end
    chk("fifo strobes", 8'h04, 8'(n_stb));
    wr(8'h10, 8'h48);
    repeat (140) @(posedge clk);
    rd(8'h12, v);
    chk("off", 8'h00, v);
    lock(8'hC8, v);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rd(8'h10, v);
    chk("reset ctrl", 8'h48, v);
    rd(8'h12, v);
    chk("reset status", 8'h00, v);
    rd(8'h13, v);
    chk("reset readback", 8'h00, v);
    tally_and_finish();
  end
endmodule : tb_mcsync_ctrl

/* File: hw/mcsync_ctrl.sv */
// What this block does
// [RULE_01] Synchronization runs only while the enable bit of the control register is one, and it is zero after reset.
// [RULE_02] The rate bit picks the data rate when one (default) and the slower FIFO reset rate when zero; the code's FIFO period is 16, not 64.
// [RULE_03] The rising edge of the sync input starts synchronization when the edge bit is one (default), else the falling edge.
// [RULE_04] Two to the power of the 3-bit averaging code phase samples, 1 to 128, are averaged to find the sync phase.
// [RULE_05] After lock the 6-bit phase request, 0 to 63 converter clock cycles, is applied as an output offset; in FIFO mode the code fires only for 0 to 15.
// [RULE_06] The offset delays the aligned output strobe against the sync input so converters can be skewed.
// [RULE_07] The lost bit reads one when lock had been reached and a later sync edge disagreed with it.
// [RULE_08] The locked bit reads one once the averaged phase has been established.
// [RULE_09] The averaged phase is read back as an 8-bit value in 6.2 fixed point.
module mcsync_ctrl #(
  parameter int DATA_PERIOD = mcsync_pkg::DATA_RATE_PERIOD,
  parameter int FIFO_PERIOD = mcsync_pkg::FIFO_RATE_PERIOD
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sync,
  input wire mcsync_pkg::mcsync_req_t i_reg,
  output mcsync_pkg::mcsync_rsp_t o_reg,
  output logic o_sync_locked,
  output logic o_sync_lost,
  output logic o_aligned_strobe
);

  // ==========================================================================
  // State
  // The accumulator is wide enough for 128 samples of phase 63.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [5:0] req;
    logic locked;
    logic lost;
    logic [7:0] readback;
    logic [2:0] pin;
    logic level;
    logic [5:0] phase_cnt;
    logic [14:0] acc;
    logic [7:0] nsamp;
    logic [5:0] ref_phase;
    logic [5:0] dly;
    logic armed;
    logic strobe;
    mcsync_pkg::mcsync_rsp_t rsp;
    mcsync_pkg::mcsync_state_t st;
  } mcsync_regs_t;

  mcsync_regs_t r;
  mcsync_regs_t next_r;

  localparam logic [5:0] DATA_LAST = 6'(DATA_PERIOD - 1);
  localparam logic [5:0] FIFO_LAST = 6'(FIFO_PERIOD - 1);

  logic [5:0] per_last;
  logic trig;
  logic [2:0] avg_code;
  logic [7:0] target;
  logic [16:0] avg_q62;
  logic [14:0] acc_sum;
  logic ctrl_wr;

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    // Pulses default low every cycle; the blocks below raise them.
    next_r.strobe = 1'b0;
    next_r.rsp.rvalid = 1'b0;
    ctrl_wr = i_reg.wr && (i_reg.addr == mcsync_pkg::ADDR_SYNC_CONTROL);
    avg_code = r.ctrl[mcsync_pkg::CTRL_AVG_LSB +: mcsync_pkg::CTRL_AVG_W];
    target = 8'h01 << avg_code; // [RULE_04]
    acc_sum = r.acc + {9'h000, r.phase_cnt};
    // The average keeps two fraction bits before the shift.
    avg_q62 = {acc_sum, 2'b00} >> avg_code; // [RULE_09]

    // The first pin flop feeds only the second; the level moves once the
    // second and third flops agree, which filters a single-cycle glitch.
    // A pin that idles high is absorbed by the level in the first cycles
    // after reset, while synchronization is still disabled.
    next_r.pin = {r.pin[1:0], i_sync};
    if (r.pin[2] == r.pin[1]) begin
      next_r.level = r.pin[2];
    end
    trig = (r.pin[2] == r.pin[1]) && (r.pin[2] != r.level)
        && (r.pin[2] == r.ctrl[mcsync_pkg::CTRL_RISING_BIT]); // [RULE_03]

    per_last = r.ctrl[mcsync_pkg::CTRL_DATA_RATE_BIT] ? DATA_LAST
        : FIFO_LAST; // [RULE_02]
    if (r.phase_cnt >= per_last) begin
      next_r.phase_cnt = 6'h00;
    end else begin
      next_r.phase_cnt = r.phase_cnt + 6'h01;
    end

    // ========================================================================
    // Register port
    // Status and readback are read-only; writes there, and to unmapped
    // addresses, are dropped.
    if (i_reg.wr) begin
      if (i_reg.addr == mcsync_pkg::ADDR_SYNC_CONTROL) begin
        next_r.ctrl = i_reg.wdata;
      end else if (i_reg.addr == mcsync_pkg::ADDR_SYNC_PHASE_REQUEST) begin
        next_r.req = i_reg.wdata[mcsync_pkg::REQ_W-1:0];
      end
    end
    if (i_reg.rd) begin
      next_r.rsp.rvalid = 1'b1;
      if (i_reg.addr == mcsync_pkg::ADDR_SYNC_CONTROL) begin
        next_r.rsp.rdata = r.ctrl;
      end else if (i_reg.addr == mcsync_pkg::ADDR_SYNC_PHASE_REQUEST) begin
        next_r.rsp.rdata = {2'b00, r.req};
      end else if (i_reg.addr == mcsync_pkg::ADDR_SYNC_STATUS) begin
        next_r.rsp.rdata = 8'h00;
        next_r.rsp.rdata[mcsync_pkg::STAT_LOST_BIT] = r.lost; // [RULE_07]
        next_r.rsp.rdata[mcsync_pkg::STAT_LOCKED_BIT] = r.locked; // [RULE_08]
      end else if (i_reg.addr == mcsync_pkg::ADDR_SYNC_PHASE_READBACK) begin
        next_r.rsp.rdata = r.readback; // [RULE_09]
      end else begin
        next_r.rsp.rdata = 8'h00;
      end
    end

    // A control write restarts acquisition and clears the lost flag, but a
    // mismatch seen in the same cycle still sets it below.
    if (ctrl_wr) begin
      next_r.lost = 1'b0;
    end

    // ========================================================================
    // Acquisition
    // Phases are summed as plain integers, so samples that straddle the
    // counter wrap average to a wrong phase; keep sync away from the wrap.
    case (r.st)
      mcsync_pkg::ST_IDLE: begin
        next_r.acc = 15'h0000;
        next_r.nsamp = 8'h00;
        if (r.ctrl[mcsync_pkg::CTRL_ENABLE_BIT] && trig) begin // [RULE_01]
          next_r.acc = {9'h000, r.phase_cnt};
          next_r.nsamp = 8'h01;
          next_r.st = mcsync_pkg::ST_AVERAGE;
          if (target == 8'h01) begin
            next_r.readback = {r.phase_cnt, 2'b00};
            next_r.ref_phase = r.phase_cnt;
            next_r.locked = 1'b1; // [RULE_08]
            next_r.st = mcsync_pkg::ST_LOCKED;
          end
        end
      end
      mcsync_pkg::ST_AVERAGE: begin
        if (trig) begin
          next_r.acc = acc_sum; // [RULE_04]
          next_r.nsamp = r.nsamp + 8'h01;
          if (r.nsamp + 8'h01 == target) begin
            next_r.readback = avg_q62[7:0];
            next_r.ref_phase = avg_q62[7:2];
            next_r.locked = 1'b1; // [RULE_08]
            next_r.st = mcsync_pkg::ST_LOCKED;
          end
        end
      end
      mcsync_pkg::ST_LOCKED: begin
        if (trig && (r.phase_cnt != r.ref_phase)) begin
          next_r.locked = 1'b0;
          next_r.lost = 1'b1; // [RULE_07]
          next_r.st = mcsync_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.st = mcsync_pkg::ST_IDLE;
      end
    endcase

    // Any control write, or clearing the enable, drops back to acquisition.
    // A lost flag raised in this same cycle survives, since nothing here
    // touches it and its clear above ran before the set.
    if (ctrl_wr || !r.ctrl[mcsync_pkg::CTRL_ENABLE_BIT]) begin // [RULE_01]
      next_r.locked = 1'b0;
      next_r.armed = 1'b0;
      next_r.st = mcsync_pkg::ST_IDLE;
    end

    // ========================================================================
    // Offset output
    // A request of a whole period or more re-arms before firing, so the strobe
    // then appears only once the delay fits between reference phases.
    if (r.locked && (r.phase_cnt == r.ref_phase)) begin
      next_r.dly = r.req; // [RULE_05]
      next_r.armed = 1'b1;
      if (r.req == 6'h00) begin
        next_r.strobe = 1'b1; // [RULE_06]
        next_r.armed = 1'b0;
      end
    end else if (r.armed) begin
      next_r.dly = r.dly - 6'h01;
      if (r.dly == 6'h01) begin
        next_r.strobe = r.locked; // [RULE_06]
        next_r.armed = 1'b0;
      end
    end
  end

  // ==========================================================================
  // Registers
  // Reset loads constants only; the phase counter restarts at zero, so the
  // phase of a given sync edge depends on when reset was released.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r <= '0;
      r.ctrl <= mcsync_pkg::CTRL_RESET;
      r.req <= mcsync_pkg::REQ_RESET;
      r.st <= mcsync_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs
  // Each output is a field of the state register, so none can glitch.
  assign o_reg = r.rsp;
  assign o_sync_locked = r.locked;
  assign o_sync_lost = r.lost;
  assign o_aligned_strobe = r.strobe;

endmodule : mcsync_ctrl

/* File: pkg/mcsync_pkg.sv */
package mcsync_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_SYNC_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_SYNC_PHASE_REQUEST = 8'h11;
  localparam logic [7:0] ADDR_SYNC_STATUS = 8'h12;
  localparam logic [7:0] ADDR_SYNC_PHASE_READBACK = 8'h13;

  // ==========================================================================
  // Field positions
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_DATA_RATE_BIT = 6;
  localparam int CTRL_RISING_BIT = 3;
  localparam int CTRL_AVG_LSB = 0;
  localparam int CTRL_AVG_W = 3;
  localparam int REQ_W = 6;
  localparam int STAT_LOST_BIT = 7;
  localparam int STAT_LOCKED_BIT = 6;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h48;
  localparam logic [5:0] REQ_RESET = 6'h00;

  // ==========================================================================
  // Timing counts in converter clock cycles
  localparam int DATA_RATE_PERIOD = 64;
  localparam int FIFO_RATE_PERIOD = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_AVERAGE = 3'b010,
    ST_LOCKED = 3'b100
  } mcsync_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mcsync_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } mcsync_rsp_t;

endpackage : mcsync_pkg
